// ==== bkss_pkg.sv ====
// package for the backup supply source select block
package bkss_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    // printed offset 0x6B is not a multiple of four: it is an index
    localparam logic [7:0] BKSS_CTRL_IDX = 8'h6B;
    localparam logic [9:0] BKSS_CTRL_ADDR = {BKSS_CTRL_IDX, 2'b00};
    localparam logic [9:0] BKSS_STAT_ADDR = 10'h1B0;
    localparam int BKSS_ADDR_W = 10;
    // ----------------------------------------
    // fields
    // ----------------------------------------
    localparam int BKSS_VSEL_LSB = 0;
    localparam int BKSS_VSEL_W = 3;
    localparam logic [2:0] BKSS_VSEL_RESET = 3'h6;
    localparam logic [2:0] BKSS_CODE_1V0 = 3'h0;
    localparam logic [2:0] BKSS_CODE_1V8 = 3'h5;
    localparam logic [2:0] BKSS_CODE_3V0 = 3'h6;
    localparam logic [2:0] BKSS_CODE_RSVD = 3'h7;
    // status field positions
    localparam int BKSS_ST_MODE_LSB = 0;
    localparam int BKSS_ST_LEVEL_LSB = 4;
    localparam int BKSS_ST_SEEN_BIT = 8;
    localparam int BKSS_ST_MAIN_BIT = 9;
    // ----------------------------------------
    // responses and modes
    // ----------------------------------------
    localparam logic [1:0] BKSS_RESP_OKAY = 2'h0;
    localparam logic [1:0] BKSS_RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        BKSS_MAIN_LDO,
        BKSS_COIN_LDO,
        BKSS_COIN_SWITCH
    } bkss_mode_t;
endpackage

// ==== bkss_top.sv ====
// backup supply source select: mode control and control register
// Contract
// (R1) the backup output stays enabled always and nothing can turn it off.
// (R2) with both supplies present the main input powers the output when above threshold.
// (R3) codes 000..110 select 1.0,1.1,1.2,1.3,1.5,1.8,3.0 V and 111 is reserved.
// (R4) on coin cell with code 110 the coin cell is switched straight to the output.
// (R5) on coin cell with codes 000..101 a regulator makes the selected level.
// (R6) the select field resets to 110 unless the programmed value differs.
// (R7) on the first coin cell power-up before any main input the output is 1.0 V.
// (R8) the level leaves 1.0 V for the set code only after the main input appears.
// (R9) losing the main input gives switch mode for 110 and same-level regulation otherwise.
// (R10) code 110 uses the high threshold pair and other codes the low pair.
// (R11) the selected code takes effect only while a valid supply is present.
// (R12) hysteresis holds the source between the rising and falling thresholds.
// (R13) software must not write the reserved code 111.
`timescale 1ns/1ns
module bkss_top (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // programmed default
    input wire logic otp_valid_i,
    input wire logic [2:0] otp_vsel_i,
    // comparator results
    input wire logic coin_present_i,
    input wire logic high_pair_rising_threshold_i,
    input wire logic high_pair_falling_threshold_i,
    input wire logic low_pair_rising_threshold_i,
    input wire logic low_pair_falling_threshold_i,
    // axi4-lite write address
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // regulator controls
    output logic always_on_backup_output_en_o,
    output logic main_source_sel_o,
    output logic coin_switch_on_o,
    output logic coin_ldo_on_o,
    output logic [2:0] backup_voltage_level_o
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [2:0] backup_voltage_select_reg;
    logic otp_loaded_reg;
    logic main_seen_reg;
    logic main_above_reg;
    logic main_above_next;
    bkss_pkg::bkss_mode_t mode_reg;
    bkss_pkg::bkss_mode_t mode_next;
    logic [2:0] level_next;
    logic aw_held_reg;
    logic w_held_reg;
    logic [9:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic w_lane0_reg;
    logic do_write;
    logic resp_wait;
    logic high_pair;
    logic [31:0] status_word;

    // ----------------------------------------
    // decoding helpers
    // ----------------------------------------
    // one decode serves the write response, the register write and the read mux,
    // so a register cannot be mapped in one place and forgotten in another
    function automatic logic hits_ctrl(input logic [9:0] addr);
        return addr == bkss_pkg::BKSS_CTRL_ADDR;
    endfunction

    function automatic logic hits_stat(input logic [9:0] addr);
        return addr == bkss_pkg::BKSS_STAT_ADDR;
    endfunction

    // only the switch code moves the comparison to the upper pair
    function automatic logic uses_high_pair(input logic [2:0] code);
        return code == bkss_pkg::BKSS_CODE_3V0;
    endfunction

    // a channel stays closed while it holds a beat or a response is unanswered
    function automatic logic ready_for(input logic held, input logic hs, input logic pending);
        return !(held || hs || pending);
    endfunction

    // ----------------------------------------
    // write channel
    // ----------------------------------------
    // address and data are latched independently so either may come first
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 10'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_lane0_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_lane0_reg <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

    // a response still waiting for bready blocks new beats; otherwise a second
    // write could be accepted and then sit behind the first with no answer
    assign resp_wait = s_axi_bvalid && !s_axi_bready;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            s_axi_awready <= ready_for(aw_held_reg, s_axi_awvalid && s_axi_awready, resp_wait);
            s_axi_wready <= ready_for(w_held_reg, s_axi_wvalid && s_axi_wready, resp_wait);
            if (do_write) begin
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= bkss_pkg::BKSS_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            // writes to the status word are acknowledged but change nothing
            if (hits_ctrl(aw_addr_reg)) begin
                s_axi_bresp <= bkss_pkg::BKSS_RESP_OKAY;
            end else if (hits_stat(aw_addr_reg)) begin
                s_axi_bresp <= bkss_pkg::BKSS_RESP_OKAY;
            end else begin
                s_axi_bresp <= bkss_pkg::BKSS_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // control register
    // ----------------------------------------
    // the programmed value is taken once, on the first clock after reset;
    // a bus write on that same edge would lose, so software starts one later
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            backup_voltage_select_reg <= bkss_pkg::BKSS_VSEL_RESET; // (R6)
            otp_loaded_reg <= 1'b0;
        end else if (!otp_loaded_reg) begin
            otp_loaded_reg <= 1'b1;
            if (otp_valid_i) begin
                backup_voltage_select_reg <= otp_vsel_i; // (R6)
            end
        end else if (do_write && w_lane0_reg
                     && hits_ctrl(aw_addr_reg)) begin
            // a reserved code is stored as written; its effect is left undefined
            backup_voltage_select_reg <= w_data_reg[bkss_pkg::BKSS_VSEL_LSB +: 3]; // (R13)
        end
    end

    // ----------------------------------------
    // status word
    // ----------------------------------------
    // read-only view of the live selection; unused bits read as zero
    always_comb begin
        status_word = 32'h00000000;
        status_word[bkss_pkg::BKSS_ST_MODE_LSB +: 2] = mode_reg;
        status_word[bkss_pkg::BKSS_ST_LEVEL_LSB +: 3] = backup_voltage_level_o;
        status_word[bkss_pkg::BKSS_ST_SEEN_BIT] = main_seen_reg;
        status_word[bkss_pkg::BKSS_ST_MAIN_BIT] = main_above_reg;
    end

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    // read data is captured at the address handshake and held until rready,
    // so a mode change during a stalled read does not tear the returned word
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= bkss_pkg::BKSS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= bkss_pkg::BKSS_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            if (hits_ctrl(s_axi_araddr)) begin
                s_axi_rdata[bkss_pkg::BKSS_VSEL_LSB +: 3] <= backup_voltage_select_reg;
            end else if (hits_stat(s_axi_araddr)) begin
                s_axi_rdata <= status_word;
            end else begin
                s_axi_rresp <= bkss_pkg::BKSS_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------
    // source comparison
    // ----------------------------------------
    // the pair follows the stored code at once, so a code change can move the
    // source on the next clock even with a steady main input
    assign high_pair = uses_high_pair(backup_voltage_select_reg); // (R10)

    // inputs in the band between thresholds keep the previous source;
    // the comparators are taken as ideal, so this is the only hysteresis
    always_comb begin
        main_above_next = main_above_reg; // (R12)
        if (high_pair) begin
            if (high_pair_rising_threshold_i) begin
                main_above_next = 1'b1; // (R10)
            end else if (!high_pair_falling_threshold_i) begin
                main_above_next = 1'b0;
            end
        end else begin
            if (low_pair_rising_threshold_i) begin
                main_above_next = 1'b1; // (R10)
            end else if (!low_pair_falling_threshold_i) begin
                main_above_next = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            main_above_reg <= 1'b0;
        end else begin
            main_above_reg <= main_above_next;
        end
    end

    // the first-power flag is cleared only by the very first main input;
    // it is volatile, so a full reset brings back the 1.0 V start level
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            main_seen_reg <= 1'b0;
        end else if (main_above_next) begin
            main_seen_reg <= 1'b1; // (R8)
        end
    end

    // ----------------------------------------
    // mode and level selection
    // ----------------------------------------
    // priority: main input, then first power, then the code-dependent coin mode
    always_comb begin
        mode_next = bkss_pkg::BKSS_MAIN_LDO;
        level_next = backup_voltage_select_reg; // (R3)
        if (main_above_next) begin
            mode_next = bkss_pkg::BKSS_MAIN_LDO; // (R2)
        end else if (!main_seen_reg) begin
            mode_next = bkss_pkg::BKSS_COIN_LDO;
            level_next = bkss_pkg::BKSS_CODE_1V0; // (R7)
        end else if (high_pair) begin
            mode_next = bkss_pkg::BKSS_COIN_SWITCH; // (R4) (R9)
        end else begin
            mode_next = bkss_pkg::BKSS_COIN_LDO; // (R5) (R9)
        end
        // without any valid supply the last applied level is held
        if (!main_above_next && !coin_present_i) begin
            mode_next = mode_reg; // (R11)
            level_next = backup_voltage_level_o;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_reg <= bkss_pkg::BKSS_COIN_LDO;
            backup_voltage_level_o <= bkss_pkg::BKSS_CODE_1V0;
        end else begin
            mode_reg <= mode_next;
            backup_voltage_level_o <= level_next;
        end
    end

    // the source controls are decoded from the next mode so they switch on the
    // same edge as mode_reg; decoding mode_reg would add a cycle of mismatch
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            main_source_sel_o <= 1'b0;
            coin_switch_on_o <= 1'b0;
            coin_ldo_on_o <= 1'b1;
        end else begin
            main_source_sel_o <= (mode_next == bkss_pkg::BKSS_MAIN_LDO);
            coin_switch_on_o <= (mode_next == bkss_pkg::BKSS_COIN_SWITCH);
            coin_ldo_on_o <= (mode_next == bkss_pkg::BKSS_COIN_LDO);
        end
    end

    // the enable is high in reset as well: nothing in this block may drop it
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            always_on_backup_output_en_o <= 1'b1;
        end else begin
            always_on_backup_output_en_o <= 1'b1; // (R1)
        end
    end
endmodule

// ==== bkss_supply_model.sv ====
// behavioural supplies: main input comparators and coin cell presence
`timescale 1ns/1ns
module bkss_supply_model #(
    parameter int LOW_RISE_MV = 2400,
    parameter int LOW_FALL_MV = 2350,
    parameter int HIGH_RISE_MV = 3100,
    parameter int HIGH_FALL_MV = 3050,
    parameter int COIN_MIN_MV = 1800
) (
    // supply levels in millivolts
    input wire logic [15:0] main_mv_i,
    input wire logic [15:0] coin_mv_i,
    // comparator results
    output logic coin_present_o,
    output logic high_rise_o,
    output logic high_fall_o,
    output logic low_rise_o,
    output logic low_fall_o
);
    // ideal comparators: any hysteresis must come from the block itself
    assign coin_present_o = coin_mv_i >= COIN_MIN_MV;
    assign high_rise_o = main_mv_i > HIGH_RISE_MV;
    assign high_fall_o = main_mv_i > HIGH_FALL_MV;
    assign low_rise_o = main_mv_i > LOW_RISE_MV;
    assign low_fall_o = main_mv_i > LOW_FALL_MV;
endmodule

// ==== bkss_top_properties.sv ====
// checker for the backup supply source select block
`timescale 1ns/1ns
module bkss_top_properties (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // comparators
    input wire logic coin_present_i,
    input wire logic high_pair_rising_threshold_i,
    input wire logic high_pair_falling_threshold_i,
    input wire logic low_pair_falling_threshold_i,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // regulator controls
    input wire logic always_on_backup_output_en_o,
    input wire logic main_source_sel_o,
    input wire logic coin_switch_on_o,
    input wire logic coin_ldo_on_o,
    input wire logic [2:0] backup_voltage_level_o
);
    logic main_seen_reg;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) main_seen_reg <= 1'h0;
        else if (main_source_sel_o) main_seen_reg <= 1'h1;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_backup_always_on: assert property (always_on_backup_output_en_o)
        else $error("backup enable low");
    a_one_source: assert property ($onehot({main_source_sel_o, coin_switch_on_o, coin_ldo_on_o}))
        else $error("mode not one-hot");
    a_main_takes_over: assert property (high_pair_rising_threshold_i |=> main_source_sel_o)
        else $error("main not taken");
    a_coin_fallback: assert property (coin_present_i && !low_pair_falling_threshold_i
        |=> !main_source_sel_o)
        else $error("main kept when low");
    a_hold_between: assert property (!high_pair_rising_threshold_i
        && high_pair_falling_threshold_i && main_source_sel_o |=> main_source_sel_o)
        else $error("source toggled");
    a_switch_at_3v0: assert property (coin_switch_on_o |-> backup_voltage_level_o == 3'h6)
        else $error("switch with other code");
    a_ldo_below_3v0: assert property (coin_ldo_on_o && main_seen_reg
        |-> backup_voltage_level_o != 3'h6)
        else $error("coin ldo at 3.0 code");
    a_first_level: assert property (!main_seen_reg && !main_source_sel_o
        |-> backup_voltage_level_o == 3'h0)
        else $error("first level not 1.0");
    a_write_answer: assert property (s_write_taken |-> ##2 s_axi_bvalid)
        else $error("late write response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("late read data");
endmodule
bind bkss_top bkss_top_properties u_props (.*);

// ==== bkss_top_tb_top.sv ====
// self-checking testbench for the backup supply source select block
`timescale 1ns/1ns
module bkss_top_tb_top;
    logic ref_clk_i = 1'h0, arst_n_i = 1'h0, otp_valid_i = 1'h0;
    logic [2:0] otp_vsel_i = 3'h5, code = 3'h6, backup_voltage_level_o;
    logic [15:0] main_mv = 16'h0, coin_mv = 16'hBB8;
    logic coin_present_i, high_pair_rising_threshold_i, high_pair_falling_threshold_i;
    logic low_pair_rising_threshold_i, low_pair_falling_threshold_i;
    logic [9:0] s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, src = 1'h0, seen = 1'h0, ta, tw;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic always_on_backup_output_en_o, main_source_sel_o, coin_switch_on_o, coin_ldo_on_o;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int errors = 0, n_checks = 0, seed = 75643, i, k;
    always #2 ref_clk_i = ~ref_clk_i;
    bkss_top uut (.*);
    bkss_supply_model u_sup (.main_mv_i(main_mv), .coin_mv_i(coin_mv),
        .coin_present_o(coin_present_i), .high_rise_o(high_pair_rising_threshold_i),
        .high_fall_o(high_pair_falling_threshold_i), .low_rise_o(low_pair_rising_threshold_i),
        .low_fall_o(low_pair_falling_threshold_i));
    function automatic logic exp_src(input int mv, input logic hi, input logic prev);
        if (mv > (hi ? 3100 : 2400)) return 1'h1;
        if (mv > (hi ? 3050 : 2350)) return prev;
        return 1'h0;
    endfunction
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", s, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    // each wait decides at the falling edge and acts at the next rising edge
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (k = 0; k < 40; k++) begin
            @(negedge ref_clk_i);
            {ta, tw, r} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bresp};
            @(posedge ref_clk_i);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        if (k == 40) begin
            errors++;
            give_verdict();
        end
    endtask
    task automatic rd(input logic [9:0] a);
        @(posedge ref_clk_i);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (k = 0; k < 40; k++) begin
            @(negedge ref_clk_i);
            {ta, v, r} = {s_axi_arvalid & s_axi_arready, s_axi_rdata, s_axi_rresp};
            @(posedge ref_clk_i);
            if (ta) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        if (k == 40) begin
            errors++;
            give_verdict();
        end
    endtask
    initial begin
        repeat (16) @(posedge ref_clk_i);
        arst_n_i <= 1'h1;
        step(2);
        chk("first level", 3'h0, backup_voltage_level_o);
        chk("first coin ldo", 1'h1, coin_ldo_on_o);
        wr(10'h3FC, 32'h5);
        chk("unmapped write resp", 2'h2, r);
        rd(10'h3FC);
        chk("unmapped read resp", 2'h2, r);
        rd(bkss_pkg::BKSS_CTRL_ADDR);
        chk("select after reset", 32'h6, v);
        for (i = 0; i < 60; i++) begin
            if (i % 6 == 0) begin
                code = 3'({$random(seed)} % 7);
                wr(bkss_pkg::BKSS_CTRL_ADDR, {29'h0, code});
                rd(bkss_pkg::BKSS_CTRL_ADDR);
                chk("select readback", {29'h0, code}, v);
                src = exp_src(main_mv, code == 3'h6, src);
                seen |= src;
            end
            @(posedge ref_clk_i);
            main_mv <= 16'(2300 + {$random(seed)} % 900);
            step(2);
            src = exp_src(main_mv, code == 3'h6, src);
            seen |= src;
            chk("main source", src, main_source_sel_o);
            chk("coin switch", !src && seen && code == 3'h6, coin_switch_on_o);
            chk("level", seen ? code : 3'h0, backup_voltage_level_o);
        end
        // second reset with a programmed default and no main input
        @(posedge ref_clk_i);
        {arst_n_i, otp_valid_i, main_mv} <= {2'h1, 16'h0};
        repeat (2) @(posedge ref_clk_i);
        arst_n_i <= 1'h1;
        rd(bkss_pkg::BKSS_CTRL_ADDR);
        chk("programmed select", 32'h5, v);
        chk("level before main", 3'h0, backup_voltage_level_o);
        @(posedge ref_clk_i);
        main_mv <= 16'hCE4;
        step(2);
        chk("level after main", 3'h5, backup_voltage_level_o);
        rd(bkss_pkg::BKSS_STAT_ADDR);
        chk("status word", 32'h350, v);
        s_axi_wstrb <= 4'h0;
        wr(bkss_pkg::BKSS_CTRL_ADDR, 32'h2);
        s_axi_wstrb <= 4'hF;
        rd(bkss_pkg::BKSS_CTRL_ADDR);
        chk("masked write", 32'h5, v);
        @(posedge ref_clk_i);
        {main_mv, coin_mv} <= 32'h0;
        step(2);
        chk("held level", 3'h5, backup_voltage_level_o);
        chk("held source", 1'h1, main_source_sel_o);
        give_verdict();
    end
endmodule
